/* core/lspt_pkg.sv */
// shared constants and types of the led slot pulse timing block
package lspt_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_TRIM = 8'h25;
	localparam logic [7:0] IDX_SHAPE_A = 8'h30;
	localparam logic [7:0] IDX_TRAIN_A = 8'h31;
	localparam logic [7:0] IDX_LIGHT_OFF = 8'h34;
	localparam logic [7:0] IDX_SHAPE_B = 8'h35;
	localparam logic [7:0] IDX_TRAIN_B = 8'h36;
	localparam logic [7:0] IDX_GLOBAL = 8'h3C;
	localparam logic [7:0] IDX_SLOT_CTRL = 8'h3E;

	// storage slots of the register file
	localparam int NUM_REGS = 7;
	localparam logic [2:0] RS_TRIM = 3'h0;
	localparam logic [2:0] RS_SHAPE_A = 3'h1;
	localparam logic [2:0] RS_TRAIN_A = 3'h2;
	localparam logic [2:0] RS_LIGHT_OFF = 3'h3;
	localparam logic [2:0] RS_SHAPE_B = 3'h4;
	localparam logic [2:0] RS_TRAIN_B = 3'h5;
	localparam logic [2:0] RS_GLOBAL = 3'h6;

	localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
		16'h3006, 16'h0818, 16'h0320, 16'h0000, 16'h0818, 16'h0320, 16'h630C
	};

	// field layout
	localparam int TRIM_W = 5;
	localparam int TRIM1_LSB = 0;
	localparam int TRIM2_LSB = 6;
	localparam int TRIM3_LSB = 11;
	localparam int WIDTH_LSB = 8;
	localparam int WIDTH_W = 5;
	localparam int DELAY_LSB = 0;
	localparam int COUNT_LSB = 8;
	localparam int PERIOD_LSB = 0;
	localparam int BYTE_W = 8;
	localparam int OFF_A_BIT = 8;
	localparam int OFF_B_BIT = 9;
	localparam int CATHODE_BIT = 9;
	localparam int SLEEP_LSB = 3;
	localparam int SLEEP_W = 6;
	localparam int CHANNELS = 4;
	localparam int CTRL_A_BIT = 0;
	localparam int CTRL_B_BIT = 1;

	// timing: all slot figures are in 1 us steps
	localparam int STEP_NS = 1000;
	localparam int CLK_NS = 8;
	localparam int STEP_CYCLES = STEP_NS / CLK_NS;

	typedef struct packed {
		logic [BYTE_W-1:0] delay;
		logic [WIDTH_W-1:0] width;
		logic [BYTE_W-1:0] count;
		logic [BYTE_W-1:0] period;
	} lspt_cfg_s;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_PULSE} lspt_seq_e;

endpackage

/* core/lspt_us_tick.sv */
// one-cycle tick every microsecond
module lspt_us_tick import lspt_pkg::*; #(
	parameter int CYCLES = STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} lspt_tick_s;

	lspt_tick_s s, next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == 8'(CYCLES - 1)) begin
			next_s.cnt = 8'h00;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick |=> !tick [*2]) else $error("tick repeated too soon");
endmodule

/* core/lspt_slot_seq.sv */
// pulse train sequencer for one time slot
module lspt_slot_seq import lspt_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic start,
	input wire lspt_cfg_s cfg,
	input wire logic light_off,
	output logic busy,
	output logic light
);
	typedef struct packed {
		lspt_seq_e st;
		lspt_cfg_s cfg;
		logic [7:0] us;
		logic [7:0] done;
		logic busy;
		logic light;
	} lspt_seq_s;

	lspt_seq_s s, next_s;

	always_comb begin
		next_s = s;
		unique case (s.st)
			SEQ_IDLE: begin
				// settings are latched so a mid-slot write cannot tear the train
				if (start && cfg.count != 8'h00) begin
					next_s.cfg = cfg;
					next_s.us = 8'h00;
					next_s.done = 8'h00;
					next_s.st = (cfg.delay == 8'h00) ? SEQ_PULSE : SEQ_DELAY;
				end
			end
			SEQ_DELAY: begin
				if (tick) begin
					if (s.us + 8'h01 >= s.cfg.delay) begin
						next_s.us = 8'h00;
						next_s.st = SEQ_PULSE;
					end else begin
						next_s.us = s.us + 8'h01;
					end
				end
			end
			SEQ_PULSE: begin
				if (tick) begin
					if (s.us + 8'h01 >= s.cfg.period) begin
						next_s.us = 8'h00;
						next_s.done = s.done + 8'h01;
						if (s.done + 8'h01 >= s.cfg.count) begin
							next_s.st = SEQ_IDLE;
						end
					end else begin
						next_s.us = s.us + 8'h01;
					end
				end
			end
		endcase
		next_s.busy = next_s.st != SEQ_IDLE;
		// disable only gates the current; the slot keeps its timing
		next_s.light = next_s.st == SEQ_PULSE && next_s.us < 8'(next_s.cfg.width) && !light_off;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{st: SEQ_IDLE, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign busy = s.busy;
	assign light = s.light;

	// helper: rising edges of light in the current slot
	logic [8:0] rises;
	logic light_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rises <= 9'h000;
			light_d <= 1'b0;
		end else begin
			light_d <= s.light;
			if (start && !s.busy) begin
				rises <= 9'h000;
			end else if (s.light && !light_d) begin
				rises <= rises + 9'h001;
			end
		end
	end

	light_in_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
		light |-> busy) else $error("light outside slot");
	light_off_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		light_off |=> !light) else $error("light while disabled");
	pulse_total_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) && s.cfg.width != 5'h00 && s.cfg.width < 5'(s.cfg.period) && !light_off && !$past(light_off)
		|-> rises == {1'b0, s.cfg.count}) else $error("wrong pulse count");
	slot_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		start && !busy && cfg.count != 8'h00 |=> busy) else $error("slot did not start");
endmodule

/* core/lspt_top.sv */
// led slot pulse timing: apb registers, two slot sequencers, front end controls
//
// Operation
// - three 5-bit driver trims, reset 12
// - per-slot 5-bit pulse width, reset 3
// - per-slot 8-bit pulse delay, reset 32
// - per-slot 8-bit pulse count, reset 8
// - slot A 8-bit period, reset 24
// - slot B independent period, reset 24
// - slot B light off suppresses pulses
// - slot A light off suppresses pulses
// - light off keeps slot running
// - decode channel sleep select to channels
// - cathode bias select output bit
//
// Our own choice: the APB interface to the registers.
module lspt_top import lspt_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int TICK_CYCLES = STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [TRIM_W-1:0] drv1_current_trim,
	output logic [TRIM_W-1:0] drv2_current_trim,
	output logic [TRIM_W-1:0] drv3_current_trim,
	output logic first_slot_busy,
	output logic second_slot_busy,
	output logic first_slot_light,
	output logic second_slot_light,
	output logic cathode_bias_high,
	output logic [CHANNELS-1:0] channel_sleep
);

	typedef struct packed {
		logic [NUM_REGS-1:0][15:0] regs;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic start_a;
		logic start_b;
		logic cathode;
		logic [CHANNELS-1:0] sleep;
	} lspt_top_s;

	typedef struct packed {
		logic hit;
		logic ctrl;
		logic [2:0] slot;
	} lspt_dec_s;

	lspt_top_s s, next_s;
	lspt_dec_s dec;
	logic tick;
	logic busy_a, busy_b;
	lspt_cfg_s cfg_a, cfg_b;

	// word index to storage slot; misaligned byte addresses miss
	function automatic lspt_dec_s decode(input logic [ADDR_W-1:0] a);
		lspt_dec_s d;
		logic [7:0] idx;
		d = '{hit: 1'b1, ctrl: 1'b0, slot: RS_TRIM};
		idx = a[9:2];
		if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != '0) begin
			d.hit = 1'b0;
		end else begin
			unique case (idx)
				IDX_TRIM: d.slot = RS_TRIM;
				IDX_SHAPE_A: d.slot = RS_SHAPE_A;
				IDX_TRAIN_A: d.slot = RS_TRAIN_A;
				IDX_LIGHT_OFF: d.slot = RS_LIGHT_OFF;
				IDX_SHAPE_B: d.slot = RS_SHAPE_B;
				IDX_TRAIN_B: d.slot = RS_TRAIN_B;
				IDX_GLOBAL: d.slot = RS_GLOBAL;
				IDX_SLOT_CTRL: d.ctrl = 1'b1;
				default: d.hit = 1'b0;
			endcase
		end
		return d;
	endfunction

	// channel 1 never sleeps; field bits 3..5 put channels 2..4 down
	function automatic logic [CHANNELS-1:0] sleep_map(input logic [15:0] g);
		logic [SLEEP_W-1:0] f;
		f = g[SLEEP_LSB +: SLEEP_W];
		return {f[5], f[4], f[3], 1'b0};
	endfunction

	function automatic lspt_cfg_s slot_cfg(input logic [15:0] shape, input logic [15:0] train);
		lspt_cfg_s c;
		c.delay = shape[DELAY_LSB +: BYTE_W];
		c.width = shape[WIDTH_LSB +: WIDTH_W];
		c.count = train[COUNT_LSB +: BYTE_W];
		c.period = train[PERIOD_LSB +: BYTE_W];
		return c;
	endfunction

	always_comb begin
		dec = decode(paddr);
	end

	always_comb begin
		next_s = s;
		next_s.start_a = 1'b0;
		next_s.start_b = 1'b0;
		next_s.pready = psel && !penable;
		next_s.pslverr = psel && !penable && !dec.hit;
		// read data is prepared in the setup cycle so pready can answer at once
		if (psel && !penable) begin
			next_s.prdata = 32'h0000_0000;
			if (dec.hit && dec.ctrl) begin
				next_s.prdata[CTRL_A_BIT] = busy_a;
				next_s.prdata[CTRL_B_BIT] = busy_b;
			end else if (dec.hit) begin
				next_s.prdata[15:0] = s.regs[dec.slot];
			end
		end
		if (psel && penable && s.pready && pwrite && dec.hit) begin
			if (dec.ctrl) begin
				next_s.start_a = pwdata[CTRL_A_BIT];
				next_s.start_b = pwdata[CTRL_B_BIT];
			end else begin
				// reserved bits are stored as written; keeping them is software's part
				next_s.regs[dec.slot] = pwdata[15:0];
			end
		end
		next_s.cathode = next_s.regs[RS_GLOBAL][CATHODE_BIT];
		next_s.sleep = sleep_map(next_s.regs[RS_GLOBAL]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{regs: REG_RESET, sleep: '0, default: '0};
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		cfg_a = slot_cfg(s.regs[RS_SHAPE_A], s.regs[RS_TRAIN_A]);
		cfg_b = slot_cfg(s.regs[RS_SHAPE_B], s.regs[RS_TRAIN_B]);
	end

	lspt_us_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	lspt_slot_seq u_slot_a (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(s.start_a),
		.cfg(cfg_a),
		.light_off(s.regs[RS_LIGHT_OFF][OFF_A_BIT]),
		.busy(busy_a),
		.light(first_slot_light)
	);

	lspt_slot_seq u_slot_b (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(s.start_b),
		.cfg(cfg_b),
		.light_off(s.regs[RS_LIGHT_OFF][OFF_B_BIT]),
		.busy(busy_b),
		.light(second_slot_light)
	);

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign drv1_current_trim = s.regs[RS_TRIM][TRIM1_LSB +: TRIM_W];
	assign drv2_current_trim = s.regs[RS_TRIM][TRIM2_LSB +: TRIM_W];
	assign drv3_current_trim = s.regs[RS_TRIM][TRIM3_LSB +: TRIM_W];
	assign first_slot_busy = busy_a;
	assign second_slot_busy = busy_b;
	assign cathode_bias_high = s.cathode;
	assign channel_sleep = s.sleep;

	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready) else $error("apb answer timing");
	unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !decode(paddr).hit |=> pslverr) else $error("unmapped access not flagged");
	period_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && pwrite && paddr == ADDR_W'({IDX_TRAIN_B, 2'b00})
		|=> s.regs[RS_TRAIN_B] == $past(pwdata[15:0])) else $error("slot b train not written");
	sleep_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.regs[RS_GLOBAL][SLEEP_LSB +: SLEEP_W] == 6'h38 |-> channel_sleep == 4'hE) else $error("sleep decode");
	awake_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.regs[RS_GLOBAL][SLEEP_LSB +: SLEEP_W] == 6'h00 |-> channel_sleep == 4'h0) else $error("channels not awake");
	cathode_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		cathode_bias_high == s.regs[RS_GLOBAL][CATHODE_BIT]) else $error("cathode bias mismatch");
	trim_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && pwrite && paddr == ADDR_W'({IDX_TRIM, 2'b00})
		|=> drv3_current_trim == $past(pwdata[15:11])) else $error("trim not applied");
	dark_slot_runs_a: assert property (@(posedge pclk) disable iff (!presetn)
		first_slot_busy && s.regs[RS_LIGHT_OFF][OFF_A_BIT] |=> !first_slot_light) else $error("slot a lit");

endmodule

/* tb/lspt_led_sink.sv */
// led sink model: counts and times the current pulses of one slot
module lspt_led_sink (
	input wire logic pclk,
	input wire logic busy,
	input wire logic light,
	output logic [15:0] pulses,
	output logic [15:0] width_cyc,
	output logic [15:0] gap_cyc,
	output logic [15:0] lead_cyc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev_light = 1'b0;
	logic prev_busy = 1'b0;
	logic [15:0] run = '0;
	logic [15:0] since = '0;
	logic [15:0] age = '0;
	// outputs have one driver; only pulses is cleared at the start of each slot unless light rises in that same cycle, the timing outputs keep their last value
	// a sink only takes current; it never pushes back on the driver
	always @(posedge pclk) begin
		prev_light <= light;
		prev_busy <= busy;
		age <= (busy && !prev_busy) ? 16'h1 : age + 16'h1;
		if (busy && !prev_busy)
			pulses <= '0;
		if (light && !prev_light) begin
			pulses <= pulses + 16'h1;
			if (pulses == 16'h0)
				lead_cyc <= age;
			gap_cyc <= since;
			since <= 16'h1;
			run <= 16'h1;
		end else begin
			since <= since + 16'h1;
			run <= light ? run + 16'h1 : run;
		end
		if (!light && prev_light)
			width_cyc <= run;
	end
endmodule

/* tb/lspt_top_test.sv */
// self-checking bench of the led slot pulse timing block
module lspt_top_test import lspt_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps slot runs brief
	localparam int TK = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, cathode_bias_high;
	logic [TRIM_W-1:0] t1, t2, t3;
	logic [1:0] busy, light;
	logic [CHANNELS-1:0] channel_sleep;
	logic [15:0] pulses [2], wid [2], gap [2], lead [2];
	int err_count = 0, n_checks = 0, cycles = 0;

	lspt_top #(.TICK_CYCLES(TK)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .drv1_current_trim(t1), .drv2_current_trim(t2), .drv3_current_trim(t3),
		.first_slot_busy(busy[0]), .second_slot_busy(busy[1]), .first_slot_light(light[0]),
		.second_slot_light(light[1]), .cathode_bias_high, .channel_sleep);
	for (genvar i = 0; i < 2; i++) begin : g_sink
		lspt_led_sink sink (.pclk(pclk), .busy(busy[i]), .light(light[i]), .pulses(pulses[i]),
			.width_cyc(wid[i]), .gap_cyc(gap[i]), .lead_cyc(lead[i]));
	end

	initial forever #4 pclk = ~pclk;

	task print_verdict;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task settle;
		repeat (2) @(negedge pclk);
	endtask

	task apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			err_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task test_reset;
		logic [7:0] idx [7];
		logic [15:0] exp [7];
		idx = '{IDX_TRIM, IDX_SHAPE_A, IDX_TRAIN_A, IDX_LIGHT_OFF, IDX_SHAPE_B, IDX_TRAIN_B, IDX_GLOBAL};
		exp = '{16'h630C, 16'h0320, 16'h0818, 16'h0000, 16'h0320, 16'h0818, 16'h3006};
		settle();
		chk("trims", {t3, t2, t1}, {3{5'h0C}});
		chk("outputs", {busy, light, cathode_bias_high, channel_sleep}, '0);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, idx[i], '0);
			chk("reset value", rd, {16'h0, exp[i]});
			chk("mapped err", 32'(er), 32'h0);
		end
		apb(1'b0, 8'h40, '0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, '0);
	endtask

	task test_trim;
		logic [15:0] v [2];
		v = '{16'hF815, 16'h0FC0};
		foreach (v[i]) begin
			apb(1'b1, IDX_TRIM, v[i]);
			settle();
			chk("trims", {t3, t2, t1}, {v[i][15:11], v[i][10:6], v[i][4:0]});
			apb(1'b0, IDX_TRIM, '0);
			chk("trim readback", rd, {16'h0, v[i]});
		end
	endtask

	task test_global;
		logic [15:0] v [2];
		logic [4:0] e [2];
		// reserved fields carry their reset values (as in 16'h3006) in both writes
		v = '{16'h31C6, 16'h3206};
		e = '{5'b01110, 5'b10000};
		foreach (v[i]) begin
			apb(1'b1, IDX_GLOBAL, v[i]);
			settle();
			chk("front end", {cathode_bias_high, channel_sleep}, e[i]);
		end
	endtask

	task run_slot(input int s, input logic off);
		logic [15:0] sh, tr;
		int n, d;
		sh = s ? 16'h0102 : 16'h0203;
		tr = s ? 16'h0303 : 16'h0605;
		d = sh[7:0];
		apb(1'b1, s ? IDX_SHAPE_B : IDX_SHAPE_A, sh);
		apb(1'b1, s ? IDX_TRAIN_B : IDX_TRAIN_A, tr);
		apb(1'b1, IDX_LIGHT_OFF, off ? (16'h0100 << s) : 16'h0000);
		apb(1'b1, IDX_SLOT_CTRL, 16'h1 << s);
		settle();
		apb(1'b0, IDX_SLOT_CTRL, '0);
		chk("slot running", 32'(rd[s]), 32'h1);
		n = 0;
		while (busy[s] !== 1'b0 && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		if (busy[s] !== 1'b0)
			err_count++;
		settle();
		chk("pulses", pulses[s], off ? 0 : tr[15:8]);
		if (!off) begin
			chk("width", wid[s], 32'(sh[12:8] * TK));
			chk("period", gap[s], 32'(tr[7:0] * TK));
			chk("delay", 32'(lead[s] + 1 >= (d - 1) * TK && lead[s] <= d * TK + 2), 32'h1);
		end
	endtask

	task test_slots;
		for (int off = 0; off < 2; off++)
			for (int s = 0; s < 2; s++)
				run_slot(s, off[0]);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_trim();
		test_global();
		test_slots();
		print_verdict();
	end
endmodule
